// file: rtl/pte_top.sv
// module: pci target path with prefetch, delayed read and error reporting
// What this block does
// - Target local address in outbound pci window cancels transfer, sets target error.
// - Target space counts as prefetchable; memory and io reads are prefetched.
// - Prefetch stops once eight words sit in the transmit fifo.
// - After the last requested read word, leftover prefetched words are flushed.
// - Writes accept single byte, aligned half, full word and all-off dummy enables.
// - Any other write enable pattern drops data and sets byte-enable error.
// - While a delayed read waits, reads to other addresses are retried.
// - Writes still complete while a delayed read is pending.
// - Pending delayed read keeps fetching into fifo, then completes from it.
// - Parity and system error signalling switchable by command register bits.
// - Every error or status event except a target access to a disabled space always sets its pending bit.
// - Pending and enabled bits raise interrupt line fourteen through controller mask.
// - Writing one to force register sets matching pending bit.
// - Pending bits clear only by software writing one.
// - Initiator resets on all-ones control write; target on state 0xF, flush, abort.
// - Target reads keep prefetching after hits so bursts continue.
// - Pci clock and reset both low release all driven pci pins.
// - Config register writable locally as host bridge, remotely as satellite.
`timescale 1ns/1ps
`default_nettype none
module pte_top
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // axi4-lite register slave
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [pte_pkg::DW-1:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [31:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [pte_pkg::DW-1:0] RDATA,
   output logic [1:0] RRESP,
   // target request from pci side
   input wire logic T_VALID,
   output logic T_READY,
   input wire logic T_WRITE,
   input wire logic T_IO,
   input wire logic [31:0] T_ADDR,
   input wire logic [3:0] T_BE_N,
   input wire logic [pte_pkg::DW-1:0] T_WDATA,
   input wire logic T_LAST,
   input wire logic T_DPERR,
   input wire logic T_APERR,
   // target answer
   output logic T_DONE,
   output logic T_RETRY,
   output logic T_ERR,
   output logic [pte_pkg::DW-1:0] T_RDATA,
   // local memory
   output logic L_WE,
   output logic [31:0] L_WADDR,
   output logic [pte_pkg::DW-1:0] L_WDATA,
   output logic [3:0] L_WSTRB,
   output logic L_RE,
   output logic [31:0] L_RADDR,
   input wire logic L_RVALID,
   input wire logic [pte_pkg::DW-1:0] L_RDATA,
   // remote configuration write
   input wire logic CFG_WE,
   input wire logic [pte_pkg::DW-1:0] CFG_WDATA,
   // pins and role
   input wire logic HOST_ROLE_SELECT_N,
   input wire logic PCI_CLK_LVL,
   input wire logic PCI_RST_N,
   input wire logic INIT_REQ,
   output logic REQ_N_O,
   output logic REQ_N_OE_N,
   output logic PERR_N_O,
   output logic PERR_N_OE_N,
   output logic SERR_N_O,
   output logic SERR_N_OE_N,
   // initiator side
   input wire logic [pte_pkg::INIT_EV_W-1:0] INIT_EV_TGL,
   input wire logic [pte_pkg::DW-1:0] INIT_STATUS,
   output logic INIT_RESET,
   // interrupt controller line fourteen
   input wire logic INTC_MASK_14,
   output logic INTC_IRQ_14
);
   import pte_pkg::*;

   typedef enum logic [1:0] {PF_IDLE, PF_REQ, PF_WAIT, PF_DROP} pte_pf_t;

   typedef struct packed {
      logic aw_v;
      logic [7:0] aw_a;
      logic w_v;
      logic [DW-1:0] w_d;
      logic [3:0] w_s;
      logic b_v;
      logic [1:0] b_r;
      logic r_v;
      logic [DW-1:0] r_d;
      logic [1:0] r_r;
      logic [DW-1:0] cmd;
      logic [31:0] base;
      logic [IRQ_W-1:0] en;
      logic [IRQ_W-1:0] pend;
      logic irq;
      logic init_rst;
      logic t_done;
      logic t_retry;
      logic t_err;
      logic [DW-1:0] t_rd;
      logic dr;
      logic [31:0] dr_a;
      pte_pf_t pf;
      logic [31:0] pf_a;
      logic [31:0] hd_a;
      logic l_we;
      logic [31:0] l_wa;
      logic [DW-1:0] l_wd;
      logic [3:0] l_ws;
      logic l_re;
      logic [31:0] l_ra;
      logic perr;
      logic serr;
      logic req;
      logic off;
   } pte_st_t;

   pte_st_t q;
   pte_st_t d;
   logic [INIT_EV_W-1:0] init_ev;
   logic [DW-1:0] f_dout;
   logic [TX_AW:0] f_cnt;
   logic f_empty;
   logic f_full;
   logic f_push;
   logic f_pop;
   logic f_flush;
   logic stop_pf;
   logic tgt_rst;
   logic issue;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] w1c;
   logic [IRQ_W-1:0] frc;
   logic [DW-1:0] mw;
   logic [DW-1:0] tsc_rd;
   logic tk;
   logic sp_en;
   logic rd_hit;
   logic pci_off;
   logic [31:0] laddr;

   // byte-lane merge for partial register writes
   function automatic logic [DW-1:0] wmerge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                             input logic [3:0] s);
      logic [DW-1:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
            r[b*8+:8] = n[b*8+:8];
      end
      return r;
   endfunction

   // accepted write enable patterns, active-low lanes
   function automatic logic be_legal(input logic [3:0] b);
      case (b)
         4'h7, 4'hB, 4'hD, 4'hE, 4'h3, 4'hC, 4'h0, 4'hF: be_legal = 1'b1;
         default: be_legal = 1'b0;
      endcase
   endfunction

   // far-domain initiator events
   pte_evsync u_sync (
      .clk(CLK),
      .rst_b(RST_B),
      .tgl(INIT_EV_TGL),
      .pulse(init_ev)
   );

   // target transmit fifo
   pte_txfifo u_txf (
      .clk(CLK),
      .rst_b(RST_B),
      .push(f_push),
      .din(L_RDATA),
      .pop(f_pop),
      .flush(f_flush),
      .dout(f_dout),
      .count(f_cnt),
      .empty(f_empty),
      .full(f_full)
   );

   // request decode helpers
   assign tk = T_VALID && T_READY;
   assign sp_en = T_IO ? q.cmd[CS_IO_EN] : q.cmd[CS_MEM_EN];
   assign laddr = T_IO ? (IO_LOCAL_BASE | {22'h000000, T_ADDR[9:0]})
                       : (q.base + {8'h00, T_ADDR[23:0]});
   assign rd_hit = !f_empty && (laddr == q.hd_a) && !(q.dr && laddr != q.dr_a);
   assign pci_off = !PCI_CLK_LVL && !PCI_RST_N;
   assign issue = (q.pf == PF_REQ) && !f_full;
   assign tsc_rd = {16'h0000, 4'h0, f_cnt, 2'h0, 2'h0,
                    q.dr, (q.pf != PF_IDLE), !f_empty, q.t_done};

   // next-state logic
   always_comb
   begin
      d = q;
      ev = '0;
      w1c = '0;
      frc = '0;
      f_push = 1'b0;
      f_pop = 1'b0;
      f_flush = 1'b0;
      stop_pf = 1'b0;
      tgt_rst = 1'b0;
      mw = wmerge(RST_WORD, q.w_d, q.w_s);
      d.t_done = 1'b0;
      d.t_retry = 1'b0;
      d.t_err = 1'b0;
      d.l_we = 1'b0;
      d.l_re = 1'b0;
      d.init_rst = 1'b0;
      d.perr = 1'b0;
      d.serr = 1'b0;
      // axi write capture, either order
      if (AWVALID && AWREADY)
      begin
         d.aw_v = 1'b1;
         d.aw_a = AWADDR[7:0];
      end
      if (WVALID && WREADY)
      begin
         d.w_v = 1'b1;
         d.w_d = WDATA;
         d.w_s = WSTRB;
      end
      if (q.b_v && BREADY)
         d.b_v = 1'b0;
      // axi write execute once address and data are both held
      if (q.aw_v && q.w_v && !q.b_v)
      begin
         d.aw_v = 1'b0;
         d.w_v = 1'b0;
         d.b_v = 1'b1;
         d.b_r = RESP_OKAY;
         if (q.aw_a == OFF_CMD_STATUS)
         begin
            if (!HOST_ROLE_SELECT_N)
               d.cmd = wmerge(q.cmd, q.w_d, q.w_s);
         end
         else if (q.aw_a == OFF_INIT_STATUS)
            d.b_r = RESP_OKAY;
         else if (q.aw_a == OFF_INIT_CTRL)
            d.init_rst = (mw == INIT_RST_CODE);
         else if (q.aw_a == OFF_TGT_STATUS_CTRL)
         begin
            tgt_rst = q.w_s[0] && (q.w_d[TSC_CS_LSB+:4] == TGT_RST_CODE);
            if (tgt_rst || (q.w_s[0] && (q.w_d[TSC_XFE] || q.w_d[TSC_XFF])))
            begin
               f_flush = 1'b1;
               stop_pf = 1'b1;
            end
            if (tgt_rst || (q.w_s[0] && q.w_d[TSC_XFF]))
               d.dr = 1'b0;
         end
         else if (q.aw_a == OFF_TGT_LOCAL_BASE)
            d.base = wmerge(q.base, q.w_d, q.w_s);
         else if (q.aw_a == OFF_IRQ_PENDING)
            w1c = mw[IRQ_W-1:0];
         else if (q.aw_a == OFF_IRQ_ENABLE)
            d.en = mw[IRQ_W-1:0];
         else if (q.aw_a == OFF_IRQ_FORCE)
            frc = mw[IRQ_W-1:0];
         else
            d.b_r = RESP_SLVERR;
      end
      // remote configuration write in satellite role
      if (CFG_WE && HOST_ROLE_SELECT_N)
         d.cmd = CFG_WDATA;
      // axi read
      if (q.r_v && RREADY)
         d.r_v = 1'b0;
      if (ARVALID && ARREADY)
      begin
         d.r_v = 1'b1;
         d.r_r = RESP_OKAY;
         d.r_d = '0;
         if (ARADDR[7:0] == OFF_CMD_STATUS)
            d.r_d = q.cmd;
         else if (ARADDR[7:0] == OFF_INIT_STATUS)
            d.r_d = INIT_STATUS;
         else if (ARADDR[7:0] == OFF_TGT_STATUS_CTRL)
            d.r_d = tsc_rd;
         else if (ARADDR[7:0] == OFF_TGT_LOCAL_BASE)
            d.r_d = q.base;
         else if (ARADDR[7:0] == OFF_IRQ_PENDING)
            d.r_d[IRQ_W-1:0] = q.pend;
         else if (ARADDR[7:0] == OFF_IRQ_ENABLE)
            d.r_d[IRQ_W-1:0] = q.en;
         else if (ARADDR[7:0] != OFF_INIT_CTRL && ARADDR[7:0] != OFF_IRQ_FORCE)
            d.r_r = RESP_SLVERR;
      end
      // prefetch engine, one local read in flight
      case (q.pf)
         PF_REQ:
         begin
            if (issue)
            begin
               d.l_re = 1'b1;
               d.l_ra = q.pf_a;
               d.pf = PF_WAIT;
            end
         end
         PF_WAIT:
         begin
            if (L_RVALID)
            begin
               f_push = 1'b1;
               d.pf_a = q.pf_a + WORD_STEP;
               d.pf = PF_REQ;
            end
         end
         PF_DROP:
         begin
            if (L_RVALID)
               d.pf = PF_IDLE;
         end
         default:
            d.pf = q.pf;
      endcase
      // target request
      if (tk)
      begin
         d.t_done = 1'b1;
         if (!sp_en)
            d.t_err = 1'b1;
         else if (laddr >= WIN_LO)
         begin
            d.t_err = 1'b1;
            ev[IP_TIER] = 1'b1;
         end
         else if (T_WRITE)
         begin
            if (!be_legal(T_BE_N))
            begin
               d.t_err = 1'b1;
               ev[IP_TBER] = 1'b1;
            end
            else if (T_BE_N != 4'hF)
            begin
               d.l_we = 1'b1;
               d.l_wa = laddr;
               d.l_wd = T_WDATA;
               d.l_ws = ~T_BE_N;
            end
         end
         else if (q.dr && laddr != q.dr_a)
            d.t_retry = 1'b1;
         else if (rd_hit)
         begin
            f_pop = 1'b1;
            d.t_rd = f_dout;
            d.dr = 1'b0;
            d.hd_a = q.hd_a + WORD_STEP;
            if (T_LAST)
            begin
               f_flush = 1'b1;
               stop_pf = 1'b1;
            end
         end
         else
         begin
            d.t_retry = 1'b1;
            if (!q.dr && !stop_pf && (q.pf == PF_IDLE || (q.pf == PF_REQ && !issue)))
            begin
               d.dr = 1'b1;
               d.dr_a = laddr;
               d.hd_a = laddr;
               d.pf_a = laddr;
               d.pf = PF_REQ;
               f_flush = 1'b1;
            end
         end
      end
      // stop prefetch; drain a read still in flight
      if (stop_pf)
         d.pf = (d.l_re || (q.pf == PF_WAIT && !L_RVALID)) ? PF_DROP : PF_IDLE;
      // parity and system error pins
      if (T_DPERR)
      begin
         ev[IP_TPER] = 1'b1;
         d.perr = q.cmd[CS_PAR_EN];
      end
      if (T_APERR)
      begin
         ev[IP_SERR] = 1'b1;
         d.serr = q.cmd[CS_SERR_EN] && q.cmd[CS_PAR_EN];
      end
      ev[IP_INIT_LSB+:INIT_EV_W] = init_ev;
      // pending: set wins over clear
      d.pend = (q.pend & ~w1c) | ev | frc;
      d.irq = (|(d.pend & d.en)) && INTC_MASK_14;
      d.off = pci_off;
      d.req = INIT_REQ;
   end

   // state register
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         q <= '0;
      else
         q <= d;
   end

   // handshakes
   assign AWREADY = !q.aw_v && !q.b_v;
   assign WREADY = !q.w_v && !q.b_v;
   assign ARREADY = !q.r_v;
   assign T_READY = !q.t_done;
   // registered outputs
   assign BVALID = q.b_v;
   assign BRESP = q.b_r;
   assign RVALID = q.r_v;
   assign RDATA = q.r_d;
   assign RRESP = q.r_r;
   assign T_DONE = q.t_done;
   assign T_RETRY = q.t_retry;
   assign T_ERR = q.t_err;
   assign T_RDATA = q.t_rd;
   assign L_WE = q.l_we;
   assign L_WADDR = q.l_wa;
   assign L_WDATA = q.l_wd;
   assign L_WSTRB = q.l_ws;
   assign L_RE = q.l_re;
   assign L_RADDR = q.l_ra;
   assign INIT_RESET = q.init_rst;
   assign INTC_IRQ_14 = q.irq;
   // pin drive, released while pci is held off
   assign REQ_N_O = !q.req;
   assign REQ_N_OE_N = q.off;
   assign PERR_N_O = !q.perr;
   assign PERR_N_OE_N = q.off || !q.perr;
   assign SERR_N_O = 1'b0;
   assign SERR_N_OE_N = q.off || !q.serr;

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_take_rd;
      tk && !T_WRITE && sp_en && (laddr < WIN_LO);
   endsequence
   sequence s_take_wr;
      tk && T_WRITE && sp_en && (laddr < WIN_LO);
   endsequence
   sequence s_arm;
      $rose(q.dr);
   endsequence

   property p_win;
      tk && sp_en && (laddr >= WIN_LO) |=> T_DONE && T_ERR && q.pend[IP_TIER];
   endproperty
   a_win: assert property (p_win) else $error("window hit not cancelled");
   property p_pf_max;
      f_cnt <= (TX_AW+1)'(TX_DEPTH);
   endproperty
   a_pf_max: assert property (p_pf_max) else $error("prefetch overran");
   property p_last;
      s_take_rd ##0 (rd_hit && T_LAST) |=> (f_cnt == '0) ##1 (f_cnt == '0);
   endproperty
   a_last: assert property (p_last) else $error("fifo not flushed");
   property p_be_ok;
      s_take_wr ##0 (be_legal(T_BE_N) && T_BE_N != 4'hF)
         |=> L_WE && (L_WSTRB == ~$past(T_BE_N)) && !T_ERR;
   endproperty
   a_be_ok: assert property (p_be_ok) else $error("legal write lost");
   property p_be_bad;
      s_take_wr ##0 !be_legal(T_BE_N) |=> !L_WE && T_ERR && q.pend[IP_TBER];
   endproperty
   a_be_bad: assert property (p_be_bad) else $error("bad enables kept");
   property p_dr_lock;
      s_take_rd ##0 (q.dr && laddr != q.dr_a) |=> T_RETRY && !T_ERR;
   endproperty
   a_dr_lock: assert property (p_dr_lock) else $error("other read served");
   property p_wr_dr;
      s_take_wr ##0 q.dr |=> T_DONE && !T_RETRY;
   endproperty
   a_wr_dr: assert property (p_wr_dr) else $error("write blocked");
   property p_pf_run;
      s_arm |-> ##[0:2] (L_RE && L_RADDR == q.dr_a);
   endproperty
   a_pf_run: assert property (p_pf_run) else $error("no prefetch");
   property p_perr;
      T_DPERR && q.cmd[CS_PAR_EN] && !pci_off |=> !PERR_N_OE_N && !PERR_N_O;
   endproperty
   a_perr: assert property (p_perr) else $error("perr not driven");
   property p_irq;
      INTC_IRQ_14 |-> (|(q.pend & q.en));
   endproperty
   a_irq: assert property (p_irq) else $error("stray interrupt");
   property p_force;
      (frc != '0) |=> ((q.pend & $past(frc)) == $past(frc));
   endproperty
   a_force: assert property (p_force) else $error("force ignored");
   property p_keep;
      (w1c == '0) |=> ((q.pend & $past(q.pend)) == $past(q.pend));
   endproperty
   a_keep: assert property (p_keep) else $error("pending lost");
   property p_tgt_rst;
      tgt_rst |=> !q.dr && (f_cnt == '0);
   endproperty
   a_tgt_rst: assert property (p_tgt_rst) else $error("target not reset");
   property p_off;
      pci_off |=> REQ_N_OE_N && PERR_N_OE_N && SERR_N_OE_N;
   endproperty
   a_off: assert property (p_off) else $error("pin driven while off");
   property p_cfg;
      CFG_WE && !HOST_ROLE_SELECT_N && !(q.aw_v && q.w_v) |=> $stable(q.cmd);
   endproperty
   a_cfg: assert property (p_cfg) else $error("remote config in host role");
endmodule
`default_nettype wire

// file: rtl/pte_pkg.sv
// package: offsets, fields and constants for the pci target and error block
package pte_pkg;
   // data path
   localparam int DW = 32;
   localparam int TX_DEPTH = 8;
   localparam int TX_AW = 3;
   localparam int IRQ_W = 8;
   localparam int INIT_EV_W = 4;
   // register byte offsets
   localparam logic [7:0] OFF_CMD_STATUS = 8'h00;
   localparam logic [7:0] OFF_INIT_STATUS = 8'h04;
   localparam logic [7:0] OFF_INIT_CTRL = 8'h08;
   localparam logic [7:0] OFF_TGT_STATUS_CTRL = 8'h0C;
   localparam logic [7:0] OFF_TGT_LOCAL_BASE = 8'h10;
   localparam logic [7:0] OFF_IRQ_PENDING = 8'h14;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] OFF_IRQ_FORCE = 8'h1C;
   // cmd_status_reg fields
   localparam int CS_IO_EN = 0;
   localparam int CS_MEM_EN = 1;
   localparam int CS_PAR_EN = 6;
   localparam int CS_SERR_EN = 8;
   // target_status_ctrl_reg fields
   localparam int TSC_CS_LSB = 0;
   localparam int TSC_XFE = 4;
   localparam int TSC_XFF = 5;
   localparam int TSC_CNT_LSB = 8;
   localparam logic [3:0] TGT_RST_CODE = 4'hF;
   localparam logic [31:0] INIT_RST_CODE = 32'hFFFF_FFFF;
   // irq_pending_reg bits
   localparam int IP_TIER = 0;
   localparam int IP_TBER = 1;
   localparam int IP_TPER = 2;
   localparam int IP_SERR = 3;
   localparam int IP_INIT_LSB = 4;
   // address map
   localparam logic [31:0] WIN_LO = 32'hA000_0000;
   localparam logic [31:0] IO_LOCAL_BASE = 32'h8000_0000;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/pte_evsync.sv
// module: three-flop toggle synchroniser turning far-side event toggles into pulses
`timescale 1ns/1ps
`default_nettype none
module pte_evsync
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // event toggles in, pulses out
   input wire logic [pte_pkg::INIT_EV_W-1:0] tgl,
   output logic [pte_pkg::INIT_EV_W-1:0] pulse
);
   import pte_pkg::*;

   typedef struct packed {
      logic [INIT_EV_W-1:0] s1;
      logic [INIT_EV_W-1:0] s2;
      logic [INIT_EV_W-1:0] s3;
   } pte_sync_st_t;

   pte_sync_st_t q;
   pte_sync_st_t d;

   // shift chain; s1 feeds only s2
   always_comb
   begin
      d = q;
      d.s1 = tgl;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   // state register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end

   // one pulse per toggle edge
   for (genvar i = 0; i < INIT_EV_W; i++)
   begin : g_ev
      assign pulse[i] = q.s2[i] ^ q.s3[i];
   end
endmodule
`default_nettype wire

// file: rtl/pte_txfifo.sv
// module: eight-word target transmit fifo with flush
`timescale 1ns/1ps
`default_nettype none
module pte_txfifo
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill, drain and flush
   input wire logic push,
   input wire logic [pte_pkg::DW-1:0] din,
   input wire logic pop,
   input wire logic flush,
   // status and head word
   output logic [pte_pkg::DW-1:0] dout,
   output logic [pte_pkg::TX_AW:0] count,
   output logic empty,
   output logic full
);
   import pte_pkg::*;

   typedef struct packed {
      logic [TX_DEPTH-1:0][DW-1:0] mem;
      logic [TX_AW-1:0] wp;
      logic [TX_AW-1:0] rp;
      logic [TX_AW:0] cnt;
   } pte_fifo_st_t;

   pte_fifo_st_t q;
   pte_fifo_st_t d;
   logic push_ok;
   logic pop_ok;

   assign empty = (q.cnt == '0);
   assign full = (q.cnt == (TX_AW+1)'(TX_DEPTH));
   assign push_ok = push && !full;
   assign pop_ok = pop && !empty;
   assign dout = q.mem[q.rp];
   assign count = q.cnt;

   // pointer and count update; flush drops everything
   always_comb
   begin
      d = q;
      if (flush)
      begin
         d.wp = '0;
         d.rp = '0;
         d.cnt = '0;
      end
      else
      begin
         if (push_ok)
         begin
            d.mem[q.wp] = din;
            d.wp = q.wp + 1'b1;
         end
         if (pop_ok)
            d.rp = q.rp + 1'b1;
         if (push_ok && !pop_ok)
            d.cnt = q.cnt + 1'b1;
         else if (pop_ok && !push_ok)
            d.cnt = q.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= d;
   end
endmodule
`default_nettype wire

// file: tb/pte_mem_model.sv
// local memory responder for the target read path
`timescale 1ns/1ps
`default_nettype none
module pte_mem_model
(
   // clock
   input wire logic clk,
   // read request and answer
   input wire logic re,
   input wire logic [31:0] raddr,
   output logic rvalid,
   output logic [31:0] rdata
);
   // one answer per request, next cycle; idle data keeps moving
   always @(posedge clk)
   begin
      rvalid <= re;
      rdata <= re ? ~raddr : raddr;
   end
endmodule
`default_nettype wire

// file: tb/pci_target_error_reporting_test.sv
// bench for the pci target and error block
`timescale 1ns/1ps
`default_nettype none
module pci_target_error_reporting_test;
   import pte_pkg::*;
   logic CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, T_VALID, T_WRITE;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, T_READY, T_DONE, T_RETRY, T_ERR;
   logic L_RE, L_RVALID, INTC_MASK_14, INTC_IRQ_14, T_LAST, T_DPERR, PCI_CLK_LVL, REQ_N_OE_N;
   logic aw_t, w_t, hs;
   logic [3:0] be_list [8] = '{4'h7, 4'hB, 4'hD, 4'hE, 4'h3, 4'hC, 4'h0, 4'hF};
   logic [31:0] AWADDR, WDATA, ARADDR, RDATA, T_ADDR, T_RDATA, L_RADDR, L_RDATA;
   logic [3:0] T_BE_N, INIT_EV_TGL;
   logic [2:0] tr;
   logic [31:0] rd;
   int miscompares = 0;
   int samples_checked = 0;
   pte_top i_pte_top (.CLK, .RST_B, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA,
      .WSTRB(4'hF), .BVALID, .BREADY, .BRESP(), .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY,
      .RDATA, .RRESP(), .T_VALID, .T_READY, .T_WRITE, .T_IO(1'b0), .T_ADDR, .T_BE_N,
      .T_WDATA(~T_ADDR), .T_LAST, .T_DPERR, .T_APERR(1'b0), .T_DONE, .T_RETRY,
      .T_ERR, .T_RDATA, .L_WE(), .L_WADDR(), .L_WDATA(), .L_WSTRB(), .L_RE, .L_RADDR,
      .L_RVALID, .L_RDATA, .CFG_WE(1'b0), .CFG_WDATA(WDATA), .HOST_ROLE_SELECT_N(1'b0),
      .PCI_CLK_LVL, .PCI_RST_N(PCI_CLK_LVL), .INIT_REQ(T_WRITE), .REQ_N_O(), .REQ_N_OE_N,
      .PERR_N_O(), .PERR_N_OE_N(), .SERR_N_O(), .SERR_N_OE_N(), .INIT_EV_TGL,
      .INIT_STATUS(T_ADDR), .INIT_RESET(), .INTC_MASK_14, .INTC_IRQ_14);
   pte_mem_model i_pte_mem_model (.clk(CLK), .re(L_RE), .raddr(L_RADDR), .rvalid(L_RVALID),
      .rdata(L_RDATA));
   // clock, 25 ns period
   initial
   begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   task automatic print_verdict;
      begin
         $display("checked %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      begin
         samples_checked++;
         if (s !== e)
         begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
         end
      end
   endtask
   // register write, both channels offered together; handshakes sampled mid-cycle
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      begin
         AWADDR <= {24'h0, a};
         WDATA <= d;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
         BREADY <= 1'b1;
         do
         begin
            @(negedge CLK);
            aw_t = AWVALID && AWREADY;
            w_t = WVALID && WREADY;
            hs = BVALID;
            @(posedge CLK);
            if (aw_t) AWVALID <= 1'b0;
            if (w_t) WVALID <= 1'b0;
         end
         while (hs !== 1'b1);
      end
   endtask
   task automatic axr(input logic [7:0] a);
      begin
         ARADDR <= {24'h0, a};
         ARVALID <= 1'b1;
         RREADY <= 1'b1;
         do
         begin
            @(negedge CLK);
            aw_t = ARVALID && ARREADY;
            hs = RVALID;
            rd = RDATA;
            @(posedge CLK);
            if (aw_t) ARVALID <= 1'b0;
         end
         while (hs !== 1'b1);
      end
   endtask
   // one target request, answer sampled in its single cycle
   task automatic tgt(input logic w, input logic [31:0] a, input logic [3:0] be);
      begin
         T_WRITE <= w;
         T_ADDR <= a;
         T_BE_N <= be;
         T_VALID <= 1'b1;
         do
         begin
            @(negedge CLK);
            hs = T_READY;
            @(posedge CLK);
         end
         while (hs !== 1'b1);
         T_VALID <= 1'b0;
         @(negedge CLK);
         tr = {T_DONE, T_RETRY, T_ERR};
         @(posedge CLK);
      end
   endtask
   // watchdog
   initial
   begin
      repeat (20000) @(posedge CLK);
      miscompares++;
      print_verdict;
   end
   // main sequence
   initial
   begin
      {RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, T_VALID, T_WRITE, INTC_MASK_14} = 0;
      {AWADDR, WDATA, ARADDR, T_ADDR, T_BE_N, INIT_EV_TGL, T_DPERR} = 0;
      {T_LAST, PCI_CLK_LVL} = 2'h3;
      repeat (3) @(posedge CLK);
      RST_B <= 1'b1;
      axr(OFF_TGT_STATUS_CTRL);
      chk("tsc_idle", 0, rd);
      axr(OFF_IRQ_PENDING);
      chk("pend_rst", 0, rd);
      axw(OFF_CMD_STATUS, 32'h3);
      foreach (be_list[i])
      begin
         tgt(1'b1, 32'h100, be_list[i]);
         chk("be_ok", 3'b100, tr);
      end
      tgt(1'b1, 32'h100, 4'h5);
      chk("be_bad", 3'b101, tr);
      axr(OFF_IRQ_PENDING);
      chk("pend_be", 32'h2, rd);
      axw(OFF_IRQ_PENDING, 32'h2);
      axr(OFF_IRQ_PENDING);
      chk("pend_w1c", 0, rd);
      axw(OFF_IRQ_FORCE, 32'h8);
      axw(OFF_IRQ_ENABLE, 32'h8);
      INTC_MASK_14 <= 1'b1;
      INIT_EV_TGL <= 4'h1;
      repeat (6) @(posedge CLK);
      chk("irq", 1, INTC_IRQ_14);
      axr(OFF_IRQ_PENDING);
      chk("pend_ev", 32'h18, rd);
      axw(OFF_IRQ_PENDING, 32'hFF);
      chk("irq_off", 0, INTC_IRQ_14);
      tgt(1'b0, 32'h0, 4'h0);
      chk("dr_miss", 3'b110, tr);
      tgt(1'b0, 32'h40, 4'h0);
      chk("dr_other", 3'b110, tr);
      tgt(1'b1, 32'h200, 4'h0);
      chk("dr_write", 3'b100, tr);
      repeat (40) @(posedge CLK);
      axr(OFF_TGT_STATUS_CTRL);
      chk("prefetch", 32'h800, rd & 32'hF00);
      T_LAST <= 1'b0;
      tgt(1'b0, 32'h0, 4'h0);
      chk("dr_hit", 3'b100, tr);
      chk("dr_data", 32'hFFFFFFFF, T_RDATA);
      T_LAST <= 1'b1;
      tgt(1'b0, 32'h4, 4'h0);
      chk("burst", 3'b100, tr);
      chk("burst_data", 32'hFFFFFFFB, T_RDATA);
      axr(OFF_TGT_STATUS_CTRL);
      chk("flushed", 0, rd & 32'hF00);
      axw(OFF_TGT_LOCAL_BASE, WIN_LO);
      tgt(1'b1, 32'h0, 4'h0);
      chk("win", 3'b101, tr);
      axr(OFF_IRQ_PENDING);
      chk("pend_win", 32'h1, rd);
      T_DPERR <= 1'b1;
      @(posedge CLK);
      T_DPERR <= 1'b0;
      axr(OFF_IRQ_PENDING);
      chk("pend_par", 32'h5, rd);
      chk("req_on", 0, REQ_N_OE_N);
      PCI_CLK_LVL <= 1'b0;
      repeat (2) @(posedge CLK);
      chk("req_off", 1, REQ_N_OE_N);
      print_verdict;
   end
endmodule
`default_nettype wire
